/* rtl/t8wm_timer.sv */
/*
 * Top of the 8-bit timer waveform block: AHB-Lite register slave,
 * counter with four waveform modes, compare buffering, flags and the
 * pin driver. Assumes a single-master AHB-Lite bus on hclk and an
 * external count pin asynchronous to hclk.
 */
// What this block does
// - Mode 1 counts up to MAX, then down.
// - Dual-slope is eight bits, MAX held one tick.
// - Dual-slope sets overflow at each bottom turn.
// - Dual-slope 10 clears up, sets down; 11 reverse.
// - Dual-slope compare zero low, MAX high, inverted opposite.
// - Dual-slope period 510 ticks; prescale 1 to 1024.
// - All logic on hclk; tick is count enable.
// - Mode field selects normal, dual-slope, clear-on-compare, fast.
// - Compare buffered to top in PWM; overflow placement.
// - Non-PWM actions: off, toggle, clear, set on match.
// - Fast: 10 clears match, sets top; 11 reverse.
// - PWM compare equals top: top action only.
// - Force strobe in non-PWM applies a match action.
// - Forced match raises no flag, clears no counter.
// - Force strobe reads zero, acts only non-PWM.
// - Nonzero action mode takes pin; direction enables driver.
// - Control bits: force 7, mode 6/3, action 5:4.
// - Action mode change shows at the next match.
// - Clock-select zero stops the counter.
`timescale 1ns/100ps
`default_nettype none

module t8wm_timer
   import t8wm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_count_pin,
   output logic pin_out,
   output logic pin_oe_n
);

   // Register state.
   logic [7:0] ctrl_r;
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   logic [7:0] compare_buf_r;
   logic [7:0] compare_act_r;
   logic count_down_r;
   logic count_down_nxt;
   logic block_r;
   logic overflow_flag_r;
   logic compare_match_flag_r;
   logic pin_dir_r;
   logic pin_port_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic pin_out_r;
   logic pin_oe_n_r;
   logic force_r;

   // Bus decode wires.
   wire logic addr_phase_w;
   wire logic [7:0] ofs_w;
   wire logic in_range_w;
   wire logic wr_ctrl_w;
   wire logic wr_count_w;
   wire logic wr_compare_w;
   wire logic wr_flags_w;
   wire logic wr_pin_w;
   logic [31:0] rd_mux_w;

   // Timer wires.
   wire logic timer_tick_enable;
   wire logic [1:0] waveform_mode;
   wire logic [1:0] output_action_mode;
   wire logic [2:0] clock_select;
   wire logic pwm_w;
   wire logic [7:0] top_w;
   wire logic at_max_w;
   wire logic at_top_w;
   wire logic match_w;
   wire logic match_up_w;
   wire logic top_evt_w;
   wire logic overflow_evt_w;
   wire logic force_evt_w;
   wire logic match_ignored_w;
   wire logic wave_w;

   // A transfer is taken when selected, non-idle and the bus is ready.
   assign addr_phase_w = hsel & htrans[1] & hready;
   assign ofs_w = haddr[7:0];
   assign in_range_w = haddr[31:8] == 24'h00_0000;

   // Writes land in the data phase, at the address latched before.
   assign wr_ctrl_w = wr_pend_r & (wr_addr_r == T8WM_OFS_CTRL);
   assign wr_count_w = wr_pend_r & (wr_addr_r == T8WM_OFS_COUNT);
   assign wr_compare_w = wr_pend_r & (wr_addr_r == T8WM_OFS_COMPARE);
   assign wr_flags_w = wr_pend_r & (wr_addr_r == T8WM_OFS_FLAGS);
   assign wr_pin_w = wr_pend_r & (wr_addr_r == T8WM_OFS_PIN);

   // Control fields: mode bits sit apart at 6 and 3.
   assign waveform_mode = {ctrl_r[T8WM_BIT_WGM_HIGH],
                           ctrl_r[T8WM_BIT_WGM_LOW]};
   assign output_action_mode = ctrl_r[T8WM_BIT_COM_HI:T8WM_BIT_COM_LO];
   assign clock_select = ctrl_r[T8WM_BIT_CS_HI:0];
   assign pwm_w = waveform_mode[0];

   // Top is the compare register only in clear-on-compare mode.
   assign top_w = (waveform_mode == T8WM_MODE_CTC) ? compare_act_r
                                                   : T8WM_MAX;
   assign at_max_w = count_r == T8WM_MAX;
   assign at_top_w = count_r == top_w;

   // Match is qualified by the tick; a counter write blocks one tick.
   assign match_w = timer_tick_enable & ~block_r &
                    (count_r == compare_act_r);
   // Bottom belongs to the rising slope so compare zero stays low.
   assign match_up_w = ~count_down_r | (count_r == T8WM_BOTTOM);
   assign top_evt_w = timer_tick_enable & pwm_w & at_max_w & ~count_down_r;
   // At top the value being loaded decides, so a new compare of MAX
   // takes hold in the very period in which it is loaded.
   assign match_ignored_w = pwm_w &
      ((top_evt_w ? compare_buf_r : compare_act_r) == T8WM_MAX);

   // Overflow at bottom turn in dual-slope, at MAX otherwise.
   assign overflow_evt_w = timer_tick_enable & ~wr_count_w &
      ((waveform_mode == T8WM_MODE_PHASE) ?
         (count_down_r & (count_r == T8WM_BOTTOM)) : at_max_w);

   // The force strobe is a one-cycle pulse and never stored.
   assign force_evt_w = force_r;

   // Read multiplexer; the force bit always reads back as zero.
   always_comb begin
      rd_mux_w = T8WM_RDATA_RST;
      if (in_range_w) begin
         case (ofs_w)
            T8WM_OFS_CTRL:
               rd_mux_w = {24'h00_0000, 1'b0, ctrl_r[6:0]};
            T8WM_OFS_COUNT: rd_mux_w = {24'h00_0000, count_r};
            T8WM_OFS_COMPARE: rd_mux_w = {24'h00_0000, compare_buf_r};
            T8WM_OFS_FLAGS:
               rd_mux_w = {30'h0000_0000, compare_match_flag_r,
                           overflow_flag_r};
            T8WM_OFS_PIN: rd_mux_w = {30'h0000_0000, pin_port_r, pin_dir_r};
            default: rd_mux_w = T8WM_RDATA_RST;
         endcase
      end
   end

   // Counter sequencing per mode.
   always_comb begin
      count_nxt = count_r;
      count_down_nxt = count_down_r;
      if (timer_tick_enable) begin
         case (waveform_mode)
            T8WM_MODE_PHASE: begin
               if (!count_down_r) begin
                  if (at_max_w) begin
                     count_down_nxt = 1'b1;
                     count_nxt = count_r - 8'h01;
                  end else begin
                     count_nxt = count_r + 8'h01;
                  end
               end else if (count_r == T8WM_BOTTOM) begin
                  count_down_nxt = 1'b0;
                  count_nxt = count_r + 8'h01;
               end else begin
                  count_nxt = count_r - 8'h01;
               end
            end
            T8WM_MODE_CTC: begin
               // Only a real match clears; a forced one does not.
               if (match_w && at_top_w) begin
                  count_nxt = T8WM_BOTTOM;
               end else begin
                  count_nxt = count_r + 8'h01;
               end
            end
            default: begin
               count_down_nxt = 1'b0;
               count_nxt = count_r + 8'h01;
            end
         endcase
      end
      if (!(waveform_mode == T8WM_MODE_PHASE)) begin
         count_down_nxt = 1'b0;
      end
      if (wr_count_w) begin
         count_nxt = hwdata[7:0];
      end
   end

   // Bus-side registers: answers are zero-wait and always OKAY.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= T8WM_OFS_CTRL;
         hrdata_r <= T8WM_RDATA_RST;
         hreadyout_r <= 1'b1;
      end else begin
         wr_pend_r <= addr_phase_w & hwrite & in_range_w;
         wr_addr_r <= ofs_w;
         hreadyout_r <= 1'b1;
         if (addr_phase_w && !hwrite) begin
            hrdata_r <= rd_mux_w;
         end
      end
   end

   // Control register and force strobe.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= T8WM_CTRL_RST;
         force_r <= 1'b0;
      end else begin
         force_r <= wr_ctrl_w & hwdata[T8WM_BIT_FORCE] &
                    ~hwdata[T8WM_BIT_WGM_LOW];
         if (wr_ctrl_w) begin
            ctrl_r <= {1'b0, hwdata[6:0]};
         end
      end
   end

   // Counter, direction and the one-tick match block after a write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= T8WM_COUNT_RST;
         count_down_r <= 1'b0;
         block_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         count_down_r <= count_down_nxt;
         if (wr_count_w) begin
            block_r <= 1'b1;
         end else if (timer_tick_enable) begin
            block_r <= 1'b0;
         end
      end
   end

   // Compare buffer: direct in non-PWM modes, loaded at top in PWM.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_buf_r <= T8WM_COMPARE_RST;
         compare_act_r <= T8WM_COMPARE_RST;
      end else begin
         if (wr_compare_w) begin
            compare_buf_r <= hwdata[7:0];
         end
         if (!pwm_w) begin
            compare_act_r <= wr_compare_w ? hwdata[7:0]
                                          : compare_buf_r;
         end else if (top_evt_w) begin
            compare_act_r <= compare_buf_r;
         end
      end
   end

   // Flags: hardware set wins over a same-cycle write-one clear.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overflow_flag_r <= 1'b0;
         compare_match_flag_r <= 1'b0;
      end else begin
         if (overflow_evt_w) begin
            overflow_flag_r <= 1'b1;
         end else if (wr_flags_w && hwdata[T8WM_BIT_OVF]) begin
            overflow_flag_r <= 1'b0;
         end
         // A forced match never reaches this flag.
         if (match_w) begin
            compare_match_flag_r <= 1'b1;
         end else if (wr_flags_w && hwdata[T8WM_BIT_CMP]) begin
            compare_match_flag_r <= 1'b0;
         end
      end
   end

   // Pin control and driver; the waveform takes the pin when enabled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_dir_r <= 1'b0;
         pin_port_r <= 1'b0;
         pin_out_r <= 1'b0;
         pin_oe_n_r <= 1'b1;
      end else begin
         if (wr_pin_w) begin
            pin_dir_r <= hwdata[T8WM_BIT_DIR];
            pin_port_r <= hwdata[T8WM_BIT_PORT];
         end
         pin_out_r <= (output_action_mode != T8WM_COM_OFF) ? wave_w
                                                           : pin_port_r;
         pin_oe_n_r <= ~pin_dir_r;
      end
   end

   // Prescaler and external pin tick source.
   t8wm_tick_gen u_tick (
      .hclk(hclk),
      .hresetn(hresetn),
      .clock_select(clock_select),
      .ext_pin(ext_count_pin),
      .timer_tick_enable(timer_tick_enable)
   );

   // Waveform output register.
   t8wm_wave_out u_wave (
      .hclk(hclk),
      .hresetn(hresetn),
      .waveform_mode(waveform_mode),
      .output_action_mode(output_action_mode),
      .match_evt(match_w),
      .match_up(match_up_w),
      .top_evt(top_evt_w),
      .force_evt(force_evt_w),
      .match_ignored(match_ignored_w),
      .wave_r(wave_w)
   );

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0; // Always OKAY; constant driven from reset on.
   assign pin_out = pin_out_r;
   assign pin_oe_n = pin_oe_n_r;

endmodule : t8wm_timer

`default_nettype wire

/* inc/t8wm_pkg.sv */
/*
 * Shared constants of the 8-bit timer waveform block: register byte
 * offsets, control field positions, mode codes and reset values.
 * Assumes a 32-bit AHB-Lite register bus with one register per word.
 */
package t8wm_pkg;

   // Register byte offsets.
   localparam logic [7:0] T8WM_OFS_CTRL = 8'h00;
   localparam logic [7:0] T8WM_OFS_COUNT = 8'h04;
   localparam logic [7:0] T8WM_OFS_COMPARE = 8'h08;
   localparam logic [7:0] T8WM_OFS_FLAGS = 8'h0C;
   localparam logic [7:0] T8WM_OFS_PIN = 8'h10;

   // Field positions inside timer_waveform_control.
   localparam int T8WM_BIT_FORCE = 7;
   localparam int T8WM_BIT_WGM_HIGH = 6;
   localparam int T8WM_BIT_COM_HI = 5;
   localparam int T8WM_BIT_COM_LO = 4;
   localparam int T8WM_BIT_WGM_LOW = 3;
   localparam int T8WM_BIT_CS_HI = 2;

   // Field positions inside the flag and pin registers.
   localparam int T8WM_BIT_OVF = 0;
   localparam int T8WM_BIT_CMP = 1;
   localparam int T8WM_BIT_DIR = 0;
   localparam int T8WM_BIT_PORT = 1;

   // Values after reset.
   localparam logic [7:0] T8WM_CTRL_RST = 8'h00;
   localparam logic [7:0] T8WM_COUNT_RST = 8'h00;
   localparam logic [7:0] T8WM_COMPARE_RST = 8'h00;
   localparam logic [31:0] T8WM_RDATA_RST = 32'h0000_0000;

   // Waveform mode codes.
   localparam logic [1:0] T8WM_MODE_NORMAL = 2'h0;
   localparam logic [1:0] T8WM_MODE_PHASE = 2'h1;
   localparam logic [1:0] T8WM_MODE_CTC = 2'h2;
   localparam logic [1:0] T8WM_MODE_FAST = 2'h3;

   // Output action codes.
   localparam logic [1:0] T8WM_COM_OFF = 2'h0;
   localparam logic [1:0] T8WM_COM_TOGGLE = 2'h1;
   localparam logic [1:0] T8WM_COM_CLEAR = 2'h2;
   localparam logic [1:0] T8WM_COM_SET = 2'h3;

   // Counter limits and the dual-slope period in timer ticks.
   localparam logic [7:0] T8WM_MAX = 8'hFF;
   localparam logic [7:0] T8WM_BOTTOM = 8'h00;
   localparam int T8WM_PHASE_PERIOD_TICKS = 510;

   // Prescaler divider masks on a free-running 10-bit count.
   localparam logic [9:0] T8WM_DIV8_MASK = 10'h007;
   localparam logic [9:0] T8WM_DIV64_MASK = 10'h03F;
   localparam logic [9:0] T8WM_DIV256_MASK = 10'h0FF;
   localparam logic [9:0] T8WM_DIV1024_MASK = 10'h3FF;
   localparam logic [9:0] T8WM_PRESC_RST = 10'h000;

   // Clock-select codes.
   localparam logic [2:0] T8WM_CS_STOP = 3'h0;
   localparam logic [2:0] T8WM_CS_DIV1 = 3'h1;
   localparam logic [2:0] T8WM_CS_DIV8 = 3'h2;
   localparam logic [2:0] T8WM_CS_DIV64 = 3'h3;
   localparam logic [2:0] T8WM_CS_DIV256 = 3'h4;
   localparam logic [2:0] T8WM_CS_DIV1024 = 3'h5;
   localparam logic [2:0] T8WM_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] T8WM_CS_EXT_RISE = 3'h7;

endpackage : t8wm_pkg

/* rtl/t8wm_tick_gen.sv */
/*
 * Timer tick generator: turns the clock-select code into a one-cycle
 * count enable on hclk, from a prescaler or from edges of an external
 * pin. Assumes the external pin is asynchronous to hclk.
 */
`timescale 1ns/100ps
`default_nettype none

module t8wm_tick_gen
   import t8wm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] clock_select,
   input wire logic ext_pin,
   output logic timer_tick_enable
);

   logic [9:0] presc_r;
   logic sync1_r;
   logic sync2_r;
   logic sync3_r;
   wire logic rise_w;
   wire logic fall_w;

   // Free-running prescaler and external pin synchroniser.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_r <= T8WM_PRESC_RST;
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         presc_r <= presc_r + 10'h001;
         sync1_r <= ext_pin;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Edges are taken only from the second and third stages.
   assign rise_w = sync2_r & ~sync3_r;
   assign fall_w = ~sync2_r & sync3_r;

   // Code zero never ticks, so the counter stands still.
   always_comb begin
      case (clock_select)
         T8WM_CS_STOP: timer_tick_enable = 1'b0;
         T8WM_CS_DIV1: timer_tick_enable = 1'b1;
         T8WM_CS_DIV8:
            timer_tick_enable = (presc_r & T8WM_DIV8_MASK) == T8WM_DIV8_MASK;
         T8WM_CS_DIV64:
            timer_tick_enable = (presc_r & T8WM_DIV64_MASK) == T8WM_DIV64_MASK;
         T8WM_CS_DIV256:
            timer_tick_enable =
               (presc_r & T8WM_DIV256_MASK) == T8WM_DIV256_MASK;
         T8WM_CS_DIV1024:
            timer_tick_enable = presc_r == T8WM_DIV1024_MASK;
         T8WM_CS_EXT_FALL: timer_tick_enable = fall_w;
         T8WM_CS_EXT_RISE: timer_tick_enable = rise_w;
         default: timer_tick_enable = 1'b0;
      endcase
   end

endmodule : t8wm_tick_gen

`default_nettype wire

/* rtl/t8wm_wave_out.sv */
/*
 * Waveform output register: applies set, clear or toggle actions on
 * compare matches and at top, chosen by the output action mode.
 * Assumes all event inputs are one-cycle pulses on hclk.
 */
`timescale 1ns/100ps
`default_nettype none

module t8wm_wave_out
   import t8wm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [1:0] waveform_mode,
   input wire logic [1:0] output_action_mode,
   input wire logic match_evt,
   input wire logic match_up,
   input wire logic top_evt,
   input wire logic force_evt,
   input wire logic match_ignored,
   output logic wave_r
);

   logic wave_nxt;
   wire logic pwm_w;

   assign pwm_w = waveform_mode[0];

   // The action mode is read only when an event arrives, so a new
   // setting shows first at the next match.
   always_comb begin
      wave_nxt = wave_r;
      if (!pwm_w) begin
         if (match_evt || force_evt) begin
            case (output_action_mode)
               T8WM_COM_TOGGLE: wave_nxt = ~wave_r;
               T8WM_COM_CLEAR: wave_nxt = 1'b0;
               T8WM_COM_SET: wave_nxt = 1'b1;
               default: wave_nxt = wave_r;
            endcase
         end
      end else if (waveform_mode == T8WM_MODE_FAST) begin
         if (top_evt && output_action_mode[1]) begin
            wave_nxt = ~output_action_mode[0];
         end else if (match_evt && !match_ignored &&
                      output_action_mode[1]) begin
            wave_nxt = output_action_mode[0];
         end
      end else begin
         // Dual-slope has no top action of its own; only a compare of
         // MAX turns the ignored match into an action at top.
         if (top_evt && match_ignored &&
             output_action_mode[1]) begin
            wave_nxt = ~output_action_mode[0];
         end else if (match_evt && !match_ignored &&
                      output_action_mode[1]) begin
            wave_nxt = match_up ? output_action_mode[0]
                                : ~output_action_mode[0];
         end
      end
   end

   // Output register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave_r <= 1'b0;
      end else begin
         wave_r <= wave_nxt;
      end
   end

endmodule : t8wm_wave_out

`default_nettype wire

/* dv/t8wm_load_model.sv */
/* Model of the load on the waveform pin.
   Assumes the pin has no pull resistor. */
`timescale 1ns/100ps
`default_nettype none

module t8wm_load_model (
   input wire logic hclk,
   input wire logic pin_out,
   input wire logic pin_oe_n,
   output logic level
);
   logic last_r = 1'b0;

   // A released wire must not show a stale level, so it shows the inverse.
   assign level = pin_oe_n ? ~last_r : pin_out;

   // Keep the last wire level.
   always_ff @(posedge hclk) begin
      last_r <= level;
   end
endmodule : t8wm_load_model
`default_nettype wire

/* dv/t8wm_timer_monitor.sv */
/* Port checker of the timer block.
   Bound to every instance of the top module. */
`timescale 1ns/100ps
`default_nettype none

module t8wm_timer_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic pin_out,
   input wire logic pin_oe_n
);
   logic wp;
   logic arm;
   logic [7:0] wa;
   logic [7:0] ctl_q;
   logic [1:0] pin_q;
   logic [9:0] gap;
   wire tk = hsel && htrans[1] && hready && haddr[31:8] == 24'h0;

   // Shadow of the control and pin registers; a write lands in its data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp <= 1'b0;
         wa <= 8'h00;
         ctl_q <= 8'h00;
         pin_q <= 2'h0;
      end else begin
         wp <= tk && hwrite;
         wa <= haddr[7:0];
         if (wp && wa == 8'h00) ctl_q <= hwdata[7:0];
         if (wp && wa == 8'h10) pin_q <= hwdata[1:0];
      end
   end

   // Cycles between pin rises; any write spoils the measurement.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap <= 10'h000;
         arm <= 1'b0;
      end else begin
         gap <= $rose(pin_out) ? 10'h000 : gap + 10'h001;
         arm <= !wp && (arm || $rose(pin_out));
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd_ctl;
      tk && !hwrite && haddr[7:0] == 8'h00;
   endsequence

   a_ready_high: assert property (hreadyout)
      else $error("ready dropped");
   a_resp_okay: assert property (!hresp)
      else $error("error response");
   a_force_zero: assert property (s_rd_ctl |=> !hrdata[7])
      else $error("force bit read as one");
   a_ctrl_layout: assert property
      (s_rd_ctl |=> hrdata == {25'h0, ctl_q[6:0]})
      else $error("control readback wrong");
   a_unmapped_zero: assert property
      (tk && !hwrite && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_port_follow: assert property
      (ctl_q[5:4] == 2'h0 |=> pin_out == $past(pin_q[1]))
      else $error("pin not the port bit");
   a_dir_enable: assert property
      (1'b1 |=> pin_oe_n == !$past(pin_q[0]))
      else $error("driver enable wrong");
   a_reset_idle: assert property
      ($rose(hresetn) |-> pin_oe_n && !pin_out)
      else $error("pin active after reset");
   a_phase_period: assert property
      ($rose(pin_out) && arm && ctl_q[6:0] == 7'h29 |-> gap == 10'd509)
      else $error("dual-slope period wrong");
   a_fast_period: assert property
      ($rose(pin_out) && arm && ctl_q[6:0] == 7'h69 |-> gap == 10'd255)
      else $error("fast period wrong");
endmodule : t8wm_timer_monitor

bind t8wm_timer t8wm_timer_monitor i_mon (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .pin_out, .pin_oe_n);
`default_nettype wire

/* dv/t8wm_timer_bench.sv */
/* Bench of the timer waveform block: bus tasks and mode scenarios.
   Assumes the checker binds itself and the load model sees the pin. */
`timescale 1ns/100ps
`default_nettype none

module t8wm_timer_bench
   import t8wm_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rq;
   logic hreadyout;
   logic hresp;
   logic pin_out;
   logic pin_oe_n;
   logic lvl;
   logic ext_pin = 1'b0;
   int fails = 0;
   int comparisons = 0;

   // Free-running 125 MHz clock.
   always #4 hclk = ~hclk;

   t8wm_timer i_t8wm_timer (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .ext_count_pin(ext_pin), .pin_out, .pin_oe_n);
   t8wm_load_model i_t8wm_load_model (.hclk, .pin_out, .pin_oe_n,
      .level(lvl));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk

   // One single transfer; each phase is held until hready is seen.
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rq = hrdata;
   endtask : xfer

   // Every word reads zero after reset; the unmapped one keeps nothing.
   task automatic t_reset;
      xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
      for (int a = 0; a <= 32; a += 4) begin
         xfer(1'b0, a[7:0], 32'h0);
         chk(rq, 32'h0);
      end
   endtask : t_reset

   // Forced matches with the counter stopped: set, clear, then toggle twice.
   task automatic t_force;
      logic [1:0] act [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
      logic lv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      xfer(1'b1, T8WM_OFS_PIN, 32'h1);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, T8WM_OFS_CTRL, {24'h0, 2'h2, act[i], 4'h0});
         repeat (4) @(posedge hclk);
         chk(lvl, lv[i]);
         xfer(1'b0, T8WM_OFS_CTRL, 32'h0);
         chk(rq, {26'h0, act[i], 4'h0});
      end
      xfer(1'b0, T8WM_OFS_FLAGS, 32'h0);
      chk(rq, 32'h0);
      xfer(1'b1, T8WM_OFS_CTRL, 32'h30);
      repeat (4) @(posedge hclk);
      chk(lvl, 1'b0);
   endtask : t_force

   // Stop, wrap, clear-on-compare and its force, then pin edges.
   task automatic t_count;
      xfer(1'b1, T8WM_OFS_CTRL, 32'h0);
      xfer(1'b1, T8WM_OFS_COUNT, 32'hFD);
      repeat (9) @(posedge hclk);
      xfer(1'b0, T8WM_OFS_COUNT, 32'h0);
      chk(rq, 32'hFD);
      xfer(1'b1, T8WM_OFS_CTRL, 32'h1);
      repeat (8) @(posedge hclk);
      xfer(1'b1, T8WM_OFS_CTRL, 32'h0);
      xfer(1'b0, T8WM_OFS_FLAGS, 32'h0);
      chk(rq, 32'h3);
      xfer(1'b1, T8WM_OFS_COMPARE, 32'h5);
      xfer(1'b1, T8WM_OFS_COUNT, 32'h0);
      xfer(1'b1, T8WM_OFS_FLAGS, 32'h3);
      xfer(1'b1, T8WM_OFS_CTRL, 32'h41);
      for (int i = 0; i < 12; i++) begin
         xfer(1'b0, T8WM_OFS_COUNT, 32'h0);
         chk(rq[7:0] <= 8'h05, 1'b1);
      end
      xfer(1'b1, T8WM_OFS_CTRL, 32'h40);
      xfer(1'b0, T8WM_OFS_FLAGS, 32'h0);
      chk(rq[1], 1'b1);
      xfer(1'b1, T8WM_OFS_FLAGS, 32'h3);
      xfer(1'b1, T8WM_OFS_COUNT, 32'h5);
      xfer(1'b1, T8WM_OFS_CTRL, 32'hC0);
      repeat (4) @(posedge hclk);
      xfer(1'b0, T8WM_OFS_COUNT, 32'h0);
      chk(rq, 32'h5);
      xfer(1'b0, T8WM_OFS_FLAGS, 32'h0);
      chk(rq, 32'h0);
      xfer(1'b1, T8WM_OFS_CTRL, 32'h7);
      xfer(1'b1, T8WM_OFS_COUNT, 32'h0);
      repeat (3) begin
         ext_pin <= 1'b1;
         repeat (6) @(posedge hclk);
         ext_pin <= 1'b0;
         repeat (6) @(posedge hclk);
      end
      xfer(1'b0, T8WM_OFS_COUNT, 32'h0);
      chk(rq, 32'h3);
   endtask : t_count

   // Both PWM modes; zero period in the table means a constant level.
   task automatic t_pwm;
      logic [7:0] cv [6] = '{8'h29, 8'h29, 8'h39, 8'h39, 8'h29, 8'h69};
      logic [7:0] mv [6] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h80, 8'h80};
      int hv [6] = '{0, 520, 520, 0, 256, 129};
      int pv [6] = '{0, 0, 0, 0, 510, 256};
      int h;
      int n;
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, T8WM_OFS_COMPARE, {24'h0, mv[i]});
         xfer(1'b1, T8WM_OFS_CTRL, {24'h0, cv[i]});
         xfer(1'b1, T8WM_OFS_FLAGS, 32'h3);
         repeat (600) @(posedge hclk);
         h = 0;
         n = 0;
         if (pv[i] == 0) begin
            repeat (520) begin
               @(posedge hclk);
               h += (lvl === 1'b1);
            end
         end else begin
            while (lvl !== 1'b0) @(posedge hclk);
            while (lvl !== 1'b1) @(posedge hclk);
            while (lvl === 1'b1) begin
               @(posedge hclk);
               h++;
            end
            n = h;
            while (lvl !== 1'b1) begin
               @(posedge hclk);
               n++;
            end
         end
         chk(h, hv[i]);
         chk(n, pv[i]);
         xfer(1'b0, T8WM_OFS_FLAGS, 32'h0);
         chk(rq[0], 1'b1);
      end
   endtask : t_pwm

   task automatic complete_run;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   // Main sequence after six reset cycles.
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_force();
      t_count();
      t_pwm();
      complete_run();
   end

   // The scenarios need about 7000 cycles; this cuts a hang short.
   initial begin
      repeat (40000) @(posedge hclk);
      fails++;
      complete_run();
   end
endmodule : t8wm_timer_bench
`default_nettype wire
